// *** verilog/vxg_defines.vh ***
// constants for the virtualization instruction gating block
`ifndef VXG_DEFINES_VH
`define VXG_DEFINES_VH

`define VXG_OP_W            4
`define VXG_OP_GUEST_ENTRY  4'h1
`define VXG_OP_STATE_LOAD   4'h2
`define VXG_OP_STATE_SAVE   4'h3
`define VXG_OP_GIF_CLEAR    4'h4
`define VXG_OP_GIF_SET      4'h5
`define VXG_OP_HV_CALL      4'h6
`define VXG_OP_TLB_INVAL    4'h7
`define VXG_OP_SEC_START    4'h8
`define VXG_OP_GUEST_EXIT   4'h9

`define VXG_LEAF_FEATURE    32'h0000_0001
`define VXG_LEAF_EXT_FEAT   32'h8000_0001
`define VXG_LEAF_VIRT_FEAT  32'h8000_000a
`define VXG_LEAF_HV_LO      32'h4000_0000
`define VXG_LEAF_HV_HI      32'h4000_00ff
`define VXG_HV_PRESENT_BIT  31
`define VXG_EXT_VIRT_BIT    2
`define VXG_EXT_SECURE_STARTUP_INSTR_BIT  12
`define VXG_LOCK_BIT        2

`define VXG_PAGE_BITS       12
`define VXG_ADDR_W          52

`define VXG_ST_HOST         2'h0
`define VXG_ST_GUEST        2'h1

`endif

// *** verilog/vxg_leaf_filter.v ***
// feature-leaf answer filter: hides the hypervisor-present bit and hypervisor-owned leaves
`timescale 1ns/1ps
`default_nettype none
`include "vxg_defines.vh"

module vxg_leaf_filter (
  input  wire [31:0] leaf,
  input  wire [31:0] raw_ecx,
  input  wire [31:0] raw_edx,
  output wire        undefined,
  output wire [31:0] ecx,
  output wire [31:0] edx
);
  wire is_basic;
  assign is_basic  = (leaf == `VXG_LEAF_FEATURE);
  // hypervisor range is never answered by hardware
  assign undefined = (leaf >= `VXG_LEAF_HV_LO) && (leaf <= `VXG_LEAF_HV_HI);
  assign ecx = undefined ? 32'h0000_0000 :
               (is_basic ? (raw_ecx & ~(32'h0000_0001 << `VXG_HV_PRESENT_BIT))
                         : raw_ecx);
  assign edx = undefined ? 32'h0000_0000 : raw_edx;
endmodule
`default_nettype wire

// *** verilog/vxg_gate.v ***
// instruction gating, identification answers and guest-mode entry for virtualization
`timescale 1ns/1ps
`default_nettype none
`include "vxg_defines.vh"
// What this block does
// - Guest entry, state load/save, flag clear, hypervisor call and tagged invalidate run only with the enable bit set, else fault.
// - Secure startup and flag set run when the enable bit or the secure-startup capability is set, else fault.
// - Bit 31 of the counter register of feature leaf 0x1 reads zero on real hardware.
// - Leaves 0x40000000 to 0x400000FF are left undefined by hardware for hypervisor use.
// - Guest entry takes one operand, the physical address of a 4KB-aligned control block.
// - Guest mode is entered only by guest entry, and some instructions behave differently there.
// - The control block intercept list and control bits decide intercepts and pre-run actions.

module vxg_gate #(
  parameter ADDR_W = `VXG_ADDR_W
) (
  input  wire              mclk,
  input  wire              rst,
  input  wire              clk_en,
  input  wire              instr_valid,
  input  wire [3:0]        instr_op,
  input  wire [ADDR_W-1:0] instr_operand,
  input  wire              virt_enable_bit,
  input  wire              cap_virt,
  input  wire              cap_secure_startup,
  input  wire              virt_disable_bit,
  input  wire              virt_lock_capability,
  input  wire              in_smm,
  input  wire [31:0]       intercept_list,
  input  wire [31:0]       exec_ctrl,
  input  wire              guest_op_valid,
  input  wire [4:0]        guest_op_event,
  input  wire              leaf_valid,
  input  wire [31:0]       leaf,
  input  wire [31:0]       leaf_raw_ecx,
  input  wire [31:0]       leaf_raw_edx,
  output reg               exec_ok,
  output reg               invalid_opcode_fault,
  output reg               entry_fault,
  output reg               guest_mode,
  output reg  [ADDR_W-1:0] ctrl_block_addr,
  output reg  [31:0]       active_intercepts,
  output reg  [31:0]       active_ctrl,
  output reg               pre_run_action,
  output reg               intercept_hit,
  output reg               global_int_flag,
  output reg               leaf_done,
  output reg               leaf_undefined,
  output reg  [31:0]       leaf_ecx,
  output reg  [31:0]       leaf_edx
);
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        grp_a;
  reg        grp_b;
  reg        allowed;
  wire       align_ok;
  wire       f_undef;
  wire [31:0] f_ecx;
  wire [31:0] f_edx;
  wire [31:0] ext_ecx;
  wire       entry_try;
  wire       entry_go;
  wire       entering;
  wire       leaving;
  wire       gif_clr;
  wire       gif_set;

  // extended feature leaf reports the virtualization and secure-startup capability bits of this core
  assign ext_ecx = (leaf == `VXG_LEAF_EXT_FEAT) ?
                   (leaf_raw_ecx | ({31'h0000_0000, cap_virt} << `VXG_EXT_VIRT_BIT)
                                 | ({31'h0000_0000, cap_secure_startup} << `VXG_EXT_SECURE_STARTUP_INSTR_BIT))
                   : leaf_raw_ecx;

  vxg_leaf_filter u_filt (
    .leaf      (leaf),
    .raw_ecx   (ext_ecx),
    .raw_edx   ((leaf == `VXG_LEAF_VIRT_FEAT) ?
                (leaf_raw_edx | ({31'h0000_0000, virt_lock_capability} << `VXG_LOCK_BIT))
                : leaf_raw_edx),
    .undefined (f_undef),
    .ecx       (f_ecx),
    .edx       (f_edx)
  );

  assign align_ok = (instr_operand[`VXG_PAGE_BITS-1:0] == {`VXG_PAGE_BITS{1'b0}});

  // a permitted entry only switches mode when aligned and outside the management handler
  assign entry_try = instr_valid && allowed && (instr_op == `VXG_OP_GUEST_ENTRY);
  assign entry_go  = entry_try && align_ok && !in_smm;
  assign entering  = (state_q == `VXG_ST_HOST) && (state_d == `VXG_ST_GUEST);
  assign leaving   = (state_q == `VXG_ST_GUEST) && (state_d == `VXG_ST_HOST);
  assign gif_clr   = instr_valid && allowed && (instr_op == `VXG_OP_GIF_CLEAR);
  assign gif_set   = instr_valid && allowed && (instr_op == `VXG_OP_GIF_SET);

  always @* begin
    grp_a = 1'b0;
    grp_b = 1'b0;
    case (instr_op)
      `VXG_OP_GUEST_ENTRY,
      `VXG_OP_STATE_LOAD,
      `VXG_OP_STATE_SAVE,
      `VXG_OP_GIF_CLEAR,
      `VXG_OP_HV_CALL,
      `VXG_OP_TLB_INVAL: grp_a = 1'b1;
      `VXG_OP_GIF_SET,
      `VXG_OP_SEC_START: grp_b = 1'b1;
      default: begin
        grp_a = 1'b0;
        grp_b = 1'b0;
      end
    endcase
    allowed = 1'b0;
    if (grp_a) begin
      allowed = virt_enable_bit;
    end else if (grp_b) begin
      allowed = virt_enable_bit | cap_secure_startup;
    end else if (instr_op == `VXG_OP_GUEST_EXIT) begin
      allowed = 1'b1;
    end
    state_d = state_q;
    case (state_q)
      `VXG_ST_HOST: begin
        // only a permitted, aligned entry outside the management handler switches mode
        if (instr_valid && allowed && (instr_op == `VXG_OP_GUEST_ENTRY) && align_ok &&
            !in_smm) begin
          state_d = `VXG_ST_GUEST;
        end
      end
      `VXG_ST_GUEST: begin
        if ((instr_valid && (instr_op == `VXG_OP_GUEST_EXIT)) ||
            (guest_op_valid && active_intercepts[guest_op_event])) begin
          state_d = `VXG_ST_HOST;
        end
      end
      default: state_d = `VXG_ST_HOST;
    endcase
  end

  // mode register and its copy on the output
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q    <= `VXG_ST_HOST;
      guest_mode <= 1'b0;
    end else if (clk_en) begin
      state_q    <= state_d;
      guest_mode <= (state_d == `VXG_ST_GUEST);
    end
  end

  // one-cycle answers to each instruction request
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      exec_ok              <= 1'b0;
      invalid_opcode_fault <= 1'b0;
      entry_fault          <= 1'b0;
    end else if (clk_en) begin
      exec_ok              <= instr_valid && allowed;
      invalid_opcode_fault <= instr_valid && !allowed;
      entry_fault          <= entry_try && !entry_go;
    end
  end

  // control block capture on entry; intercepts dropped on exit so the host is never caught
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_block_addr   <= {ADDR_W{1'b0}};
      active_intercepts <= 32'h0000_0000;
      active_ctrl       <= 32'h0000_0000;
      pre_run_action    <= 1'b0;
    end else if (clk_en) begin
      pre_run_action <= 1'b0;
      if (entering) begin
        ctrl_block_addr   <= instr_operand;
        active_intercepts <= intercept_list;
        active_ctrl       <= exec_ctrl;
        pre_run_action    <= |exec_ctrl;
      end else if (leaving) begin
        active_intercepts <= 32'h0000_0000;
      end
    end
  end

  // guest operation that matches the captured intercept list
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      intercept_hit <= 1'b0;
    end else if (clk_en) begin
      intercept_hit <= (state_q == `VXG_ST_GUEST) && guest_op_valid &&
                       active_intercepts[guest_op_event];
    end
  end

  // global interrupt flag: entry sets it, clear and set instructions move it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      global_int_flag <= 1'b1;
    end else if (clk_en) begin
      if (entering) begin
        global_int_flag <= 1'b1;
      end else if (!leaving && gif_clr) begin
        global_int_flag <= 1'b0;
      end else if (!leaving && gif_set) begin
        global_int_flag <= 1'b1;
      end
    end
  end

  // identification answers, held until the next query; leaf_done is high for one cycle only
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      leaf_done      <= 1'b0;
      leaf_undefined <= 1'b0;
      leaf_ecx       <= 32'h0000_0000;
      leaf_edx       <= 32'h0000_0000;
    end else if (clk_en) begin
      leaf_done <= leaf_valid;
      if (leaf_valid) begin
        leaf_undefined <= f_undef;
        leaf_ecx       <= f_ecx;
        leaf_edx       <= f_edx;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/vxg_gate_sva.sv ***
// concurrent checks on the ports of the virtualization instruction gate
`timescale 1ns/1ps
`default_nettype none
module vxg_gate_sva #(parameter ADDR_W = 52) (
  input wire logic              mclk, rst, clk_en, instr_valid, virt_enable_bit,
  input wire logic              cap_secure_startup, in_smm, guest_op_valid, leaf_valid,
  input wire logic [3:0]        instr_op,
  input wire logic [ADDR_W-1:0] instr_operand, ctrl_block_addr,
  input wire logic [4:0]        guest_op_event,
  input wire logic [31:0]       leaf, leaf_ecx, leaf_edx, active_intercepts,
  input wire logic              exec_ok, invalid_opcode_fault, entry_fault, guest_mode,
  input wire logic              intercept_hit, leaf_done, leaf_undefined
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_grp_a;
    clk_en && instr_valid && instr_op inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
  endsequence
  sequence s_grp_b;
    clk_en && instr_valid && instr_op inside {4'h5, 4'h8};
  endsequence
  sequence s_entry;
    clk_en && instr_valid && instr_op == 4'h1 && virt_enable_bit;
  endsequence
  chk_grpa_gate: assert property (s_grp_a
    |=> exec_ok == $past(virt_enable_bit) && invalid_opcode_fault == !exec_ok)
    else $error("group a gating wrong");
  chk_grpb_gate: assert property (s_grp_b
    |=> exec_ok == $past(virt_enable_bit || cap_secure_startup) && invalid_opcode_fault != exec_ok)
    else $error("group b gating wrong");
  chk_hv_bit_clear: assert property (clk_en && leaf_valid && leaf == 32'h0000_0001
    |=> leaf_done && !leaf_ecx[31]) else $error("hypervisor bit not clear");
  chk_hv_leaf_range: assert property (clk_en && leaf_valid && leaf[31:8] == 24'h40_0000
    |=> leaf_undefined && leaf_ecx == 0 && leaf_edx == 0) else $error("hypervisor leaf defined");
  chk_entry_loads: assert property (s_entry ##0 !guest_mode && !in_smm && instr_operand[11:0] == 0
    |=> guest_mode && ctrl_block_addr == $past(instr_operand)) else $error("entry did not load");
  chk_entry_misalign: assert property (s_entry ##0 !guest_mode && instr_operand[11:0] != 0
    |=> entry_fault && $stable(guest_mode)) else $error("misaligned entry accepted");
  chk_mode_source: assert property ($rose(guest_mode)
    |-> $past(clk_en && instr_valid && instr_op == 4'h1)) else $error("guest mode without entry");
  chk_intercept_exit: assert property (clk_en && guest_mode && guest_op_valid
    && active_intercepts[guest_op_event] |=> intercept_hit && !guest_mode && active_intercepts == 0)
    else $error("intercept did not exit");
endmodule
`default_nettype wire

// *** tb/vxg_gate_bench.sv ***
// self-checking bench for the virtualization instruction gate
`timescale 1ns/1ps
`default_nettype none
module vxg_gate_bench;
  logic        mclk, rst, clk_en, instr_valid, virt_enable_bit, cap_virt, cap_secure_startup;
  logic        virt_disable_bit, virt_lock_capability, in_smm, guest_op_valid, leaf_valid;
  logic        exec_ok, invalid_opcode_fault, entry_fault, guest_mode, pre_run_action;
  logic        intercept_hit, global_int_flag, leaf_done, leaf_undefined;
  logic [3:0]  instr_op;
  logic [4:0]  guest_op_event;
  logic [51:0] instr_operand, ctrl_block_addr;
  logic [31:0] intercept_list, exec_ctrl, leaf, leaf_raw_ecx, leaf_raw_edx;
  logic [31:0] active_intercepts, active_ctrl, leaf_ecx, leaf_edx;
  int          err_count, cmp_count;
  // row: opcode, enable bit, secure-startup capability, expected exec_ok
  logic [6:0]  rows [13] = '{7'h0a, 7'h0d, 7'h12, 7'h1d, 7'h20, 7'h35, 7'h3a, 7'h17,
                             7'h28, 7'h2b, 7'h40, 7'h43, 7'h45};
  vxg_gate dut (
    .mclk                 (mclk),
    .rst                  (rst),
    .clk_en               (clk_en),
    .instr_valid          (instr_valid),
    .instr_op             (instr_op),
    .instr_operand        (instr_operand),
    .virt_enable_bit      (virt_enable_bit),
    .cap_virt             (cap_virt),
    .cap_secure_startup   (cap_secure_startup),
    .virt_disable_bit     (virt_disable_bit),
    .virt_lock_capability (virt_lock_capability),
    .in_smm               (in_smm),
    .intercept_list       (intercept_list),
    .exec_ctrl            (exec_ctrl),
    .guest_op_valid       (guest_op_valid),
    .guest_op_event       (guest_op_event),
    .leaf_valid           (leaf_valid),
    .leaf                 (leaf),
    .leaf_raw_ecx         (leaf_raw_ecx),
    .leaf_raw_edx         (leaf_raw_edx),
    .exec_ok              (exec_ok),
    .invalid_opcode_fault (invalid_opcode_fault),
    .entry_fault          (entry_fault),
    .guest_mode           (guest_mode),
    .ctrl_block_addr      (ctrl_block_addr),
    .active_intercepts    (active_intercepts),
    .active_ctrl          (active_ctrl),
    .pre_run_action       (pre_run_action),
    .intercept_hit        (intercept_hit),
    .global_int_flag      (global_int_flag),
    .leaf_done            (leaf_done),
    .leaf_undefined       (leaf_undefined),
    .leaf_ecx             (leaf_ecx),
    .leaf_edx             (leaf_edx)
  );
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [51:0] a);
    @(posedge mclk); #1;
    instr_valid = 1'b1; instr_op = o; instr_operand = a;
    @(posedge mclk); #1;
    instr_valid = 1'b0;
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge mclk); #1;
    guest_op_valid = 1'b1; guest_op_event = e;
    @(posedge mclk); #1;
    guest_op_valid = 1'b0;
  endtask
  task automatic ask(input logic [31:0] l, input logic u, input logic [31:0] c);
    @(posedge mclk); #1;
    leaf_valid = 1'b1; leaf = l;
    @(posedge mclk); #1;
    leaf_valid = 1'b0;
    chk("leaf_done", 1, leaf_done);
    chk("leaf_undefined", u, leaf_undefined);
    chk("leaf_ecx", c, leaf_ecx);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {instr_valid, guest_op_valid, leaf_valid, in_smm, virt_enable_bit, cap_virt} = '0;
    {cap_secure_startup, virt_disable_bit, instr_op, guest_op_event, leaf} = '0;
    rst = 1'b1; clk_en = 1'b1; virt_lock_capability = 1'b1; instr_operand = '0;
    leaf_raw_ecx = 32'hffff_ffff; leaf_raw_edx = '0; err_count = 0; cmp_count = 0;
    intercept_list = 32'h0000_0020; exec_ctrl = 32'h0000_0004;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    chk("guest_mode", 0, guest_mode);
    chk("global_int_flag", 1, global_int_flag);
    $display("reset test done");
    foreach (rows[i]) begin
      {virt_enable_bit, cap_secure_startup} = rows[i][2:1];
      op(rows[i][6:3], 52'h1);
      chk("exec_ok", rows[i][0], exec_ok);
      chk("invalid_opcode_fault", !rows[i][0], invalid_opcode_fault);
    end
    $display("opcode table done");
    virt_enable_bit = 1'b1;
    op(4'h1, 52'h1001);
    chk("entry_fault", 1, entry_fault);
    in_smm = 1'b1;
    op(4'h1, 52'h1000);
    chk("guest_mode", 0, guest_mode);
    in_smm = 1'b0;
    op(4'h1, 52'h00ab_c000);
    chk("guest_mode", 1, guest_mode);
    chk("ctrl_block_addr", 52'h00ab_c000, ctrl_block_addr);
    chk("active_intercepts", 32'h0000_0020, active_intercepts);
    chk("active_ctrl", 32'h0000_0004, active_ctrl);
    chk("pre_run_action", 1, pre_run_action);
    ev(5'h04);
    chk("intercept_hit", 0, intercept_hit);
    ev(5'h05);
    chk("intercept_hit", 1, intercept_hit);
    chk("guest_mode", 0, guest_mode);
    $display("guest entry test done");
    op(4'h4, 52'h0);
    chk("global_int_flag", 0, global_int_flag);
    clk_en = 1'b0;
    op(4'h5, 52'h0);
    chk("exec_ok", 1, exec_ok);
    chk("global_int_flag", 0, global_int_flag);
    clk_en = 1'b1;
    rst = 1'b1;
    @(posedge mclk); #1 rst = 1'b0;
    chk("global_int_flag", 1, global_int_flag);
    chk("exec_ok", 0, exec_ok);
    op(4'h4, 52'h0);
    chk("global_int_flag", 0, global_int_flag);
    op(4'h5, 52'h0);
    chk("global_int_flag", 1, global_int_flag);
    $display("flag, clock enable and mid-run reset test done");
    ask(32'h0000_0001, 0, 32'h7fff_ffff);
    ask(32'h4000_0000, 1, 0);
    ask(32'h4000_00ff, 1, 0);
    ask(32'h4000_0100, 0, 32'hffff_ffff);
    ask(32'h8000_000a, 0, 32'hffff_ffff);
    chk("leaf_edx", 32'h0000_0004, leaf_edx);
    $display("leaf test done");
    wrap_up();
  end
  initial begin
    #20000;
    chk("watchdog", 1, 0);
    wrap_up();
  end
endmodule
bind vxg_gate vxg_gate_sva #(.ADDR_W(ADDR_W)) chk_i (
  .mclk(mclk), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
  .virt_enable_bit(virt_enable_bit), .cap_secure_startup(cap_secure_startup),
  .in_smm(in_smm), .guest_op_valid(guest_op_valid), .leaf_valid(leaf_valid),
  .instr_op(instr_op), .instr_operand(instr_operand), .ctrl_block_addr(ctrl_block_addr),
  .guest_op_event(guest_op_event), .leaf(leaf), .leaf_ecx(leaf_ecx), .leaf_edx(leaf_edx),
  .active_intercepts(active_intercepts), .exec_ok(exec_ok),
  .invalid_opcode_fault(invalid_opcode_fault), .entry_fault(entry_fault),
  .guest_mode(guest_mode), .intercept_hit(intercept_hit), .leaf_done(leaf_done),
  .leaf_undefined(leaf_undefined)
);
`default_nettype wire
